//--- hdl/ptfb_crc4.sv
// CRC-4 over one 2048 kbit/s submultiframe, result held in a register
`timescale 1ns/1ns
`include "ptfb_defines.svh"

module ptfb_crc4 (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic bit_en,
  input wire logic data_bit,
  input wire logic smf_end,
  output logic [3:0] crc_ff
);

  logic [3:0] acc_ff;
  logic [3:0] nxt_acc;
  logic [3:0] nxt_crc;
  logic fb;

  // =====================================================================
  // Serial divide by x^4 + x + 1
  always_comb begin
    fb = acc_ff[3] ^ data_bit;
    nxt_acc = acc_ff;
    nxt_crc = crc_ff;
    if (clear) begin
      nxt_acc = 4'h0;
      nxt_crc = 4'h0;
    end else if (bit_en) begin
      if (smf_end) begin
        // Remainder of the finished block goes out in the next one
        nxt_crc = {acc_ff[2:0], 1'b0} ^ {2'b00, fb, fb};
        nxt_acc = 4'h0;
      end else begin
        nxt_acc = {acc_ff[2:0], 1'b0} ^ {2'b00, fb, fb};
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_ff <= 4'h0;
      crc_ff <= 4'h0;
    end else begin
      acc_ff <= nxt_acc;
      crc_ff <= nxt_crc;
    end
  end

endmodule : ptfb_crc4

//--- hdl/ptfb_defines.svh
// Offsets, patterns and counts shared by the test frame builder files
`ifndef PTFB_DEFINES_SVH
`define PTFB_DEFINES_SVH

// =====================================================================
// Last bit index of one set, per structure
`define PTFB_LAST_BIT_E1 9'h0FF
`define PTFB_LAST_BIT_6312 9'h125
`define PTFB_LAST_BIT_8448 9'h0D3
`define PTFB_LAST_BIT_32064 9'h13F
`define PTFB_LAST_BIT_34368 9'h17F

// =====================================================================
// Last set index of one frame or multiframe, per structure
`define PTFB_LAST_SET_E1 4'hF
`define PTFB_LAST_SET_6312 4'h3
`define PTFB_LAST_SET_8448 4'h3
`define PTFB_LAST_SET_32064 4'h5
`define PTFB_LAST_SET_34368 4'h3

// =====================================================================
// 2048 kbit/s time slot 0 and time slot 16
`define PTFB_E1_TS_SIG 5'h10
`define PTFB_E1_FAS 7'h1B
`define PTFB_E1_MFAS 6'h0B
`define PTFB_E1_MFAS_LAST 3'h5
`define PTFB_E1_SMF_LAST 3'h7
`define PTFB_E1_EBIT 1'b1

// =====================================================================
// 6312 kbit/s overhead positions inside an M-subframe
`define PTFB_M_POS_M 9'h000
`define PTFB_M_POS_C1 9'h031
`define PTFB_M_POS_F1 9'h062
`define PTFB_M_POS_C2 9'h093
`define PTFB_M_POS_C3 9'h0C4
`define PTFB_M_POS_F2 9'h0F5
`define PTFB_M_ALIGN 3'h3
`define PTFB_M_F1 1'b0
`define PTFB_M_F2 1'b1
`define PTFB_M_X_DEFAULT 1'b1

// =====================================================================
// 8448 and 34 368 kbit/s sets
`define PTFB_FAS10 10'h3D0
`define PTFB_FAS10_LAST 9'h009
`define PTFB_RAI_POS 9'h00A
`define PTFB_NAT_POS 9'h00B
`define PTFB_JC4_LAST 9'h003
`define PTFB_JO4_LAST 9'h007

// =====================================================================
// 32 064 kbit/s sets
`define PTFB_FAS5_SET1 5'h1A
`define PTFB_FAS5_SET4 5'h05
`define PTFB_OH5_LAST 9'h004
`define PTFB_JO5_LAST 9'h009
`define PTFB_TRIB5 9'h005

// =====================================================================
// Value sent in a used justification slot
`define PTFB_STUFF_BIT 1'b0

`endif

//--- hdl/ptfb_frame_builder.sv
// Framed test signal builder for plesiochronous line structures
//
// Operation
// - Time slot 0 carries CRC and alignment bits
// - Slot 16 signalling, other slots test bits
// - 6312 M-frame: four subframes of 294
// - Six overhead bits, each before 48 test
// - Subframes 1-3 first bit 0,1,1; 4 alarm
// - Subframe alignment bits are 0 then 1
// - Stuff control bits zero means no stuff
// - Subframe 4 alarm bit optionally from input
// - Subframe n stuffs nth bit after F2
// - 8448 frame: four sets of 212
// - Set 1: alignment word, alarm, national bit
// - Sets 2,3: four control bits, then test
// - Set 4 bits 5-8 justification opportunities
// - 32064 M-frame: six sets of 320
// - Sets 1,4 alignment; 2,3,5 control bits
// - Set 6 auxiliary bits carry remote alarm
// - Justification slot is tributary's first set-6 bit
// - 34368 frame: four sets of 384
// - Set 1: alignment word, alarm, national bit
// - Sets 2-4 control; set 4 opportunities
// - 8448, 32064, 34368 payload slots tagged with their tributary
`timescale 1ns/1ns
`include "ptfb_defines.svh"

module ptfb_frame_builder import ptfb_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bit_en,
  input wire logic run_en,
  input wire ptfb_mode_t mode_sel,
  input wire logic [4:0] justify,
  input wire logic remote_alarm,
  input wire logic national_bit,
  input wire logic [4:0] spare_bits,
  input wire logic [7:0] signalling_bits,
  input wire logic alarm_service_en,
  input wire logic alarm_service_bit,
  input wire logic payload_test_bits,
  output logic payload_req,
  output logic [2:0] payload_trib_ff,
  output logic line_bit_ff,
  output logic line_valid_ff,
  output logic overhead_ff,
  output logic frame_start_ff,
  output ptfb_mode_t active_mode_ff,
  output logic running
);

  ptfb_run_t state_ff;
  ptfb_run_t nxt_state;
  ptfb_mode_t nxt_mode;
  logic [8:0] bit_ff;
  logic [8:0] nxt_bit;
  logic [3:0] set_ff;
  logic [3:0] nxt_set;
  logic [4:0] just_ff;
  logic [4:0] nxt_just;
  logic nxt_line_bit;
  logic nxt_line_valid;
  logic nxt_overhead;
  logic nxt_frame_start;
  logic [2:0] nxt_trib;

  logic slot_pay;
  logic slot_bit;
  logic slot_crc;
  logic [2:0] slot_trib;
  logic set_end;
  logic frame_end;
  logic emit;
  logic [3:0] crc_ff;
  logic crc_in;
  logic smf_end;

  // Patterns held as vectors so that single bits can be selected
  localparam logic [6:0] E1_FAS = `PTFB_E1_FAS;
  localparam logic [5:0] E1_MFAS = `PTFB_E1_MFAS;
  localparam logic [9:0] FAS10 = `PTFB_FAS10;
  localparam logic [4:0] FAS5_SET1 = `PTFB_FAS5_SET1;
  localparam logic [4:0] FAS5_SET4 = `PTFB_FAS5_SET4;

  // =====================================================================
  // Structure size helpers
  function automatic logic [8:0] last_bit(input ptfb_mode_t m);
    unique case (m)
      PTFB_E1_CRC4_CAS: last_bit = `PTFB_LAST_BIT_E1;
      PTFB_6312: last_bit = `PTFB_LAST_BIT_6312;
      PTFB_8448: last_bit = `PTFB_LAST_BIT_8448;
      PTFB_32064: last_bit = `PTFB_LAST_BIT_32064;
      PTFB_34368: last_bit = `PTFB_LAST_BIT_34368;
      default: last_bit = `PTFB_LAST_BIT_E1;
    endcase
  endfunction : last_bit

  function automatic logic [3:0] last_set(input ptfb_mode_t m);
    unique case (m)
      PTFB_E1_CRC4_CAS: last_set = `PTFB_LAST_SET_E1;
      PTFB_6312: last_set = `PTFB_LAST_SET_6312;
      PTFB_8448: last_set = `PTFB_LAST_SET_8448;
      PTFB_32064: last_set = `PTFB_LAST_SET_32064;
      PTFB_34368: last_set = `PTFB_LAST_SET_34368;
      default: last_set = `PTFB_LAST_SET_E1;
    endcase
  endfunction : last_set

  assign emit = (state_ff == PTFB_RUN) && bit_en;
  assign set_end = (bit_ff == last_bit(active_mode_ff));
  assign frame_end = set_end && (set_ff == last_set(active_mode_ff));
  assign running = (state_ff == PTFB_RUN);

  // =====================================================================
  // Slot classification
  always_comb begin
    slot_pay = 1'b0;
    slot_bit = 1'b0;
    slot_crc = 1'b0;
    slot_trib = 3'h0;
    unique case (active_mode_ff)
      PTFB_E1_CRC4_CAS: begin
        if (bit_ff[7:3] == 5'h00) begin
          if (!set_ff[0]) begin
            if (bit_ff[2:0] == 3'h0) begin
              slot_bit = crc_ff[3 - set_ff[2:1]];
              slot_crc = 1'b1;
            end else begin
              slot_bit = E1_FAS[3'h7 - bit_ff[2:0]];
            end
          end else begin
            unique case (bit_ff[2:0])
              3'h0: begin
                if (set_ff[3:1] <= `PTFB_E1_MFAS_LAST) begin
                  slot_bit = E1_MFAS[3'h5 - set_ff[3:1]];
                end else begin
                  slot_bit = `PTFB_E1_EBIT;
                end
              end
              3'h1: slot_bit = 1'b1;
              3'h2: slot_bit = remote_alarm;
              default: slot_bit = spare_bits[3'h7 - bit_ff[2:0]];
            endcase
          end
        end else if (bit_ff[7:3] == `PTFB_E1_TS_SIG) begin
          slot_bit = signalling_bits[3'h7 - bit_ff[2:0]];
        end else begin
          slot_pay = 1'b1;
        end
      end
      PTFB_6312: begin
        unique case (bit_ff)
          `PTFB_M_POS_M: begin
            if (set_ff == `PTFB_LAST_SET_6312) begin
              slot_bit = alarm_service_en ? alarm_service_bit : `PTFB_M_X_DEFAULT;
            end else begin
              slot_bit = (set_ff == 4'h0) ? 1'b0 : `PTFB_M_ALIGN >> 1 == 3'h1;
            end
          end
          `PTFB_M_POS_C1, `PTFB_M_POS_C2, `PTFB_M_POS_C3: begin
            slot_bit = just_ff[set_ff[1:0]];
          end
          `PTFB_M_POS_F1: slot_bit = `PTFB_M_F1;
          `PTFB_M_POS_F2: slot_bit = `PTFB_M_F2;
          default: begin
            if (bit_ff == `PTFB_M_POS_F2 + 9'h001 + {7'h00, set_ff[1:0]} && just_ff[set_ff[1:0]]) begin
              slot_bit = `PTFB_STUFF_BIT;
            end else begin
              slot_pay = 1'b1;
            end
          end
        endcase
      end
      PTFB_8448, PTFB_34368: begin
        slot_trib = {1'b0, bit_ff[1:0]};
        if (set_ff == 4'h0) begin
          if (bit_ff <= `PTFB_FAS10_LAST) begin
            slot_bit = FAS10[4'h9 - bit_ff[3:0]];
          end else if (bit_ff == `PTFB_RAI_POS) begin
            slot_bit = remote_alarm;
          end else if (bit_ff == `PTFB_NAT_POS) begin
            slot_bit = national_bit;
          end else begin
            slot_pay = 1'b1;
          end
        end else if (bit_ff <= `PTFB_JC4_LAST) begin
          slot_bit = just_ff[bit_ff[1:0]];
        end else if (set_ff == 4'h3 && bit_ff <= `PTFB_JO4_LAST && just_ff[bit_ff[1:0]]) begin
          slot_bit = `PTFB_STUFF_BIT;
        end else begin
          slot_pay = 1'b1;
        end
      end
      PTFB_32064: begin
        slot_trib = 3'((bit_ff - `PTFB_TRIB5) % `PTFB_TRIB5);
        if (bit_ff <= `PTFB_OH5_LAST) begin
          slot_trib = 3'h0;
          unique case (set_ff)
            4'h0: slot_bit = FAS5_SET1[3'h4 - bit_ff[2:0]];
            4'h3: slot_bit = FAS5_SET4[3'h4 - bit_ff[2:0]];
            4'h5: slot_bit = remote_alarm;
            default: slot_bit = just_ff[bit_ff[2:0]];
          endcase
        end else if (set_ff == 4'h5 && bit_ff <= `PTFB_JO5_LAST && just_ff[3'(bit_ff - `PTFB_TRIB5)]) begin
          slot_bit = `PTFB_STUFF_BIT;
        end else begin
          slot_pay = 1'b1;
        end
      end
      default: begin
        slot_pay = 1'b0;
      end
    endcase
  end

  // Source is stalled on every overhead or stuff slot
  assign payload_req = emit && slot_pay;

  // =====================================================================
  // CRC over each eight-frame half of the multiframe
  assign crc_in = slot_crc ? 1'b0 : (slot_pay ? payload_test_bits : slot_bit);
  assign smf_end = set_end && (set_ff[2:0] == `PTFB_E1_SMF_LAST);

  ptfb_crc4 u_crc4 (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(state_ff == PTFB_IDLE || active_mode_ff != PTFB_E1_CRC4_CAS),
    .bit_en(emit),
    .data_bit(crc_in),
    .smf_end(smf_end),
    .crc_ff(crc_ff)
  );

  // =====================================================================
  // Sequencing and line output
  always_comb begin
    nxt_state = state_ff;
    nxt_mode = active_mode_ff;
    nxt_bit = bit_ff;
    nxt_set = set_ff;
    nxt_just = just_ff;
    nxt_line_bit = line_bit_ff;
    nxt_line_valid = 1'b0;
    nxt_overhead = overhead_ff;
    nxt_frame_start = 1'b0;
    nxt_trib = payload_trib_ff;
    unique case (state_ff)
      PTFB_IDLE: begin
        // Structure only changes between runs
        nxt_mode = mode_sel;
        nxt_just = justify;
        nxt_bit = 9'h000;
        nxt_set = 4'h0;
        if (run_en) begin
          nxt_state = PTFB_RUN;
        end
      end
      PTFB_RUN: begin
        if (bit_en) begin
          nxt_line_bit = slot_pay ? payload_test_bits : slot_bit;
          nxt_line_valid = 1'b1;
          nxt_overhead = !slot_pay;
          nxt_trib = slot_trib;
          nxt_frame_start = (bit_ff == 9'h000) && (set_ff == 4'h0);
          if (frame_end) begin
            // Justification pattern held for a whole frame
            nxt_bit = 9'h000;
            nxt_set = 4'h0;
            nxt_just = justify;
            if (!run_en) begin
              nxt_state = PTFB_IDLE;
            end
          end else if (set_end) begin
            nxt_bit = 9'h000;
            nxt_set = set_ff + 4'h1;
          end else begin
            nxt_bit = bit_ff + 9'h001;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= PTFB_IDLE;
      active_mode_ff <= PTFB_E1_CRC4_CAS;
      bit_ff <= 9'h000;
      set_ff <= 4'h0;
      just_ff <= 5'h00;
      line_bit_ff <= 1'b0;
      line_valid_ff <= 1'b0;
      overhead_ff <= 1'b0;
      frame_start_ff <= 1'b0;
      payload_trib_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      active_mode_ff <= nxt_mode;
      bit_ff <= nxt_bit;
      set_ff <= nxt_set;
      just_ff <= nxt_just;
      line_bit_ff <= nxt_line_bit;
      line_valid_ff <= nxt_line_valid;
      overhead_ff <= nxt_overhead;
      frame_start_ff <= nxt_frame_start;
      payload_trib_ff <= nxt_trib;
    end
  end

endmodule : ptfb_frame_builder

//--- hdl/ptfb_pkg.sv
// Types shared by the test frame builder
package ptfb_pkg;

  // =====================================================================
  // Frame structures
  typedef enum logic [2:0] {
    PTFB_E1_CRC4_CAS,
    PTFB_6312,
    PTFB_8448,
    PTFB_32064,
    PTFB_34368
  } ptfb_mode_t;

  // =====================================================================
  // Run state
  typedef enum logic {
    PTFB_IDLE,
    PTFB_RUN
  } ptfb_run_t;

endpackage : ptfb_pkg

//--- tb/ptfb_frame_builder_monitor.sv
// Port checker for the test frame builder
`timescale 1ns/1ns
module ptfb_frame_builder_monitor import ptfb_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bit_en,
  input wire logic running,
  input wire logic payload_req,
  input wire logic payload_test_bits,
  input wire logic line_bit_ff,
  input wire logic line_valid_ff,
  input wire logic overhead_ff,
  input wire logic frame_start_ff,
  input wire ptfb_mode_t active_mode_ff
);
  // =====================================================================
  // Slot handshake and framing
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic tick;
  assign tick = bit_en & running;

  chk_tick_valid: assert property (tick |=> line_valid_ff)
    else $error("line bit missing after tick");
  chk_idle_quiet: assert property (!tick |=> !line_valid_ff)
    else $error("line bit without tick");
  chk_req_tick: assert property (payload_req |-> tick)
    else $error("payload request outside tick");
  chk_payload_pass: assert property (tick && payload_req |=> !overhead_ff && line_bit_ff == $past(payload_test_bits))
    else $error("payload bit not passed through");
  chk_overhead_mark: assert property (tick && !payload_req |=> overhead_ff)
    else $error("overhead slot not marked");
  chk_start_valid: assert property (frame_start_ff |-> line_valid_ff)
    else $error("frame start without line bit");
  chk_mode_held: assert property (running && $past(running) |-> $stable(active_mode_ff))
    else $error("structure changed while running");
  chk_start_bit: assert property (frame_start_ff && active_mode_ff != PTFB_E1_CRC4_CAS |-> line_bit_ff == (active_mode_ff != PTFB_6312))
    else $error("wrong first bit of frame");

  cover property (frame_start_ff && active_mode_ff == PTFB_6312);
  cover property (frame_start_ff && active_mode_ff == PTFB_32064);
  cover property (tick && !payload_req && active_mode_ff == PTFB_34368);
endmodule : ptfb_frame_builder_monitor

bind ptfb_frame_builder ptfb_frame_builder_monitor i_ptfb_frame_builder_monitor (
  .ref_clk(ref_clk), .rst(rst), .bit_en(bit_en), .running(running), .payload_req(payload_req),
  .payload_test_bits(payload_test_bits), .line_bit_ff(line_bit_ff), .line_valid_ff(line_valid_ff),
  .overhead_ff(overhead_ff), .frame_start_ff(frame_start_ff), .active_mode_ff(active_mode_ff));

//--- tb/ptfb_line_sink.sv
// Demultiplexer input model: counts line bits since the last frame start
`timescale 1ns/1ns
module ptfb_line_sink (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic line_valid_ff,
  input wire logic frame_start_ff,
  output logic [15:0] bit_count_ff
);
  // =====================================================================
  // Bit counter
  logic [15:0] nxt_bit_count;
  always_comb begin
    nxt_bit_count = bit_count_ff + {15'h0, line_valid_ff};
    if (frame_start_ff) begin
      nxt_bit_count = 16'h0001;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bit_count_ff <= 16'h0000;
    end else begin
      bit_count_ff <= nxt_bit_count;
    end
  end
endmodule : ptfb_line_sink

//--- tb/testbench.sv
// Self-checking bench for the test frame builder
`timescale 1ns/1ns
module testbench import ptfb_pkg::*; ;
  // =====================================================================
  // Signals
  logic ref_clk = 0, rst = 1, bit_en = 0, run_en = 0, remote_alarm = 0, national_bit = 0;
  logic alarm_service_en = 0, alarm_service_bit = 0, payload_test_bits = 0;
  ptfb_mode_t mode_sel = PTFB_E1_CRC4_CAS;
  logic [4:0] justify = 5'h00, spare_bits = 5'h00;
  logic [7:0] signalling_bits = 8'h00;
  logic payload_req, line_bit_ff, line_valid_ff, overhead_ff, frame_start_ff, running;
  logic [2:0] payload_trib_ff, e;
  ptfb_mode_t active_mode_ff;
  logic [15:0] bit_count_ff;
  logic [31:0] seed = 32'h7e5c;
  logic [6:0] exp_q[$];
  logic [6:0] n;
  logic [3:0] crc_acc = 4'h0, crc_sent = 4'h0;
  logic v_bit, fb_bit;
  int mismatches = 0, cmp_count = 0, cur_mode = 0, s_ix = 0, b_ix = 0, slots = 0;
  int set_len[5] = '{256, 294, 212, 320, 384};
  int set_num[5] = '{16, 4, 4, 6, 4};

  ptfb_frame_builder i_ptfb_frame_builder (.ref_clk(ref_clk), .rst(rst), .bit_en(bit_en), .run_en(run_en),
    .mode_sel(mode_sel), .justify(justify), .remote_alarm(remote_alarm), .national_bit(national_bit),
    .spare_bits(spare_bits), .signalling_bits(signalling_bits), .alarm_service_en(alarm_service_en),
    .alarm_service_bit(alarm_service_bit), .payload_test_bits(payload_test_bits), .payload_req(payload_req),
    .payload_trib_ff(payload_trib_ff), .line_bit_ff(line_bit_ff), .line_valid_ff(line_valid_ff),
    .overhead_ff(overhead_ff), .frame_start_ff(frame_start_ff), .active_mode_ff(active_mode_ff),
    .running(running));
  ptfb_line_sink i_ptfb_line_sink (.ref_clk(ref_clk), .rst(rst), .line_valid_ff(line_valid_ff),
    .frame_start_ff(frame_start_ff), .bit_count_ff(bit_count_ff));

  always #4 ref_clk = ~ref_clk;

  // =====================================================================
  // Helpers
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic chk(string nm, logic [15:0] ex, logic [15:0] got);
    cmp_count++;
    if (ex !== got) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // Returns {dont_care, overhead, value}; the CRC bits are not modelled here
  function automatic logic [2:0] slot_exp(int m, int s, int b);
    logic [5:0] mfa = 6'h0b;
    logic [6:0] fas7 = 7'h1b;
    logic [9:0] fas10 = 10'h3d0;
    logic [4:0] oh_a = 5'h1a;
    logic [4:0] oh_b = 5'h05;
    if (m == 0) begin
      if (b == 0) return (s % 2 == 0) ? 3'h6 : {2'h1, (s < 12) ? mfa[5 - s / 2] : 1'b1};
      if (b < 8) return {2'h1, (s % 2 == 0) ? fas7[7 - b] : (b == 1) ? 1'b1 : (b == 2) ? remote_alarm : spare_bits[7 - b]};
      if (b >= 128 && b < 136) return {2'h1, signalling_bits[135 - b]};
    end else if (m == 1) begin
      if (b == 0) return {2'h1, (s == 0) ? 1'b0 : (s < 3) ? 1'b1 : alarm_service_en ? alarm_service_bit : 1'b1};
      if (b == 49 || b == 147 || b == 196) return {2'h1, justify[s]};
      if (b == 98 || b == 245) return {2'h1, b == 245};
      if (b == 246 + s && justify[s]) return 3'h2;
    end else if (m == 3) begin
      if (b < 5) return {2'h1, (s == 0) ? oh_a[4 - b] : (s == 3) ? oh_b[4 - b] : (s == 5) ? remote_alarm : justify[b]};
      if (s == 5 && b < 10 && justify[b - 5]) return 3'h2;
    end else begin
      if (s == 0 && b < 10) return {2'h1, fas10[9 - b]};
      if (s == 0 && b < 12) return {2'h1, (b == 10) ? remote_alarm : national_bit};
      if (s > 0 && b < 4) return {2'h1, justify[b]};
      if (s == 3 && b < 8 && justify[b - 4]) return 3'h2;
    end
    return 3'h0;
  endfunction : slot_exp

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  // =====================================================================
  // Stimulus, expectation and watcher
  // Gappy ticks keep the slot logic honest about bit_en
  always @(posedge ref_clk) begin
    seed = xs(seed);
    bit_en <= seed[0] | seed[1];
    payload_test_bits <= seed[2];
  end

  always @(posedge ref_clk) begin
    if (!rst && running && bit_en) begin
      e = slot_exp(cur_mode, s_ix, b_ix);
      // C slots carry the remainder of the previous half multiframe
      if (e[2]) e = {2'h1, crc_sent[3 - (s_ix / 2) % 4]};
      v_bit = e[1] ? e[0] : payload_test_bits;
      if (cur_mode == 0) begin
        fb_bit = crc_acc[3] ^ (v_bit & !(b_ix == 0 && s_ix % 2 == 0));
        crc_acc = {crc_acc[2:0], 1'b0} ^ {2'h0, fb_bit, fb_bit};
        if (b_ix == 255 && s_ix % 8 == 7) begin
          crc_sent = crc_acc;
          crc_acc = 4'h0;
        end
      end
      chk("payload_req", !e[1], payload_req);
      chk("mode", cur_mode, active_mode_ff);
      exp_q.push_back({e[2:1], s_ix == 0 && b_ix == 0, v_bit,
        (cur_mode == 3) ? ((b_ix < 5) ? 3'h0 : 3'((b_ix - 5) % 5)) : (cur_mode >= 2) ? 3'(b_ix % 4) : 3'h0});
      slots++;
      b_ix++;
      if (b_ix == set_len[cur_mode]) begin
        b_ix = 0;
        s_ix = (s_ix + 1) % set_num[cur_mode];
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!rst && line_valid_ff && exp_q.size() == 0) chk("queue", 16'h0001, 16'h0000);
    if (!rst && line_valid_ff && exp_q.size() > 0) begin
      n = exp_q.pop_front();
      if (!n[6]) chk("line_bit", n[3], line_bit_ff);
      chk("overhead", n[5], overhead_ff);
      chk("frame_start", n[4], frame_start_ff);
      chk("trib", n[2:0], payload_trib_ff);
    end
  end

  // One multiframe per call; run_en drops at once so exactly one is built
  task automatic run_frame(int m, logic [4:0] j);
    int w;
    @(posedge ref_clk);
    mode_sel <= ptfb_mode_t'(m);
    justify <= j;
    {remote_alarm, national_bit, alarm_service_en, alarm_service_bit} <= seed[11:8];
    spare_bits <= seed[16:12];
    signalling_bits <= seed[24:17];
    run_en <= 1'b1;
    cur_mode = m;
    s_ix = 0;
    b_ix = 0;
    slots = 0;
    crc_acc = 4'h0;
    crc_sent = 4'h0;
    @(posedge ref_clk);
    run_en <= 1'b0;
    w = 0;
    while ((running || w == 0) && w < 60000) begin
      @(posedge ref_clk);
      w++;
    end
    repeat (3) @(posedge ref_clk);
    chk("stopped", 16'h0000, running);
    chk("slots", set_len[m] * set_num[m], slots);
    chk("sink_count", set_len[m] * set_num[m], bit_count_ff);
  endtask : run_frame

  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    for (int m = 0; m < 5; m++) begin
      run_frame(m, 5'h00);
      run_frame(m, 5'h1f);
      run_frame(m, seed[29:25]);
    end
    report_and_stop();
  end

  initial begin
    #800000;
    mismatches++;
    report_and_stop();
  end
endmodule : testbench
